// >>> src/progcache.sv
// program cache with invalidate registers and banked internal memory arbiter
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// R1: 32 KiB direct-mapped instruction cache serves every processor fetch.
// R2: a hit returns fetch data in the cycle after the request.
// R3: an internal ROM or RAM miss adds exactly two cycles.
// R4: lines are 256 bits, eight words, filled in one wide transfer.
// R5: lines from external memory are cached like internal ones.
// R6: mode field sits in control bits 7:5, resetting to 000b.
// R7: mode 010b enables the cache; every miss fills a line.
// R8: mode 011b serves hits but misses leave contents unchanged.
// R9: mode 100b forces every fetch to miss, contents frozen.
// R10: mode 000b acts as the deprecated enable setting.
// R11: software writes only 000b, 010b, 011b or 100b into the mode field.
// R12: mode changes never invalidate; only the invalidate registers remove lines.
// R13: invalidate start address and control registers remove cached addresses.
// R14: software invalidates affected addresses after modifying program memory.
// R15: start-up code writes 010b to enable the cache explicitly.
// R16: ROM is two 256-bit pages of four 64-bit banks.
// R17: RAM is one 256-bit page of eight 32-bit banks.
// R18: up to three internal accesses proceed at once without bank conflicts.
// R19: requesters are two 64-bit data ports, line fill, 32-bit peripheral.
// R20: a line fill conflicts only with data accesses to its page; the arbiter also stalls peripheral accesses to that page.
// R21: different pages or banks of one page run concurrently.
// R22: on conflict one requester is granted, the others stall.
module progcache (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic [31:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic FETCH_REQ,
	input wire logic [31:0] FETCH_ADDR,
	output logic FETCH_BUSY,
	output logic FETCH_VALID,
	output logic [31:0] FETCH_DATA,
	output logic FILL_MEM_EN,
	output logic [31:0] FILL_MEM_ADDR,
	input wire logic [255:0] FILL_MEM_DATA,
	output logic EXT_REQ,
	output logic [31:0] EXT_ADDR,
	input wire logic EXT_ACK,
	input wire logic [255:0] EXT_DATA,
	input wire logic D0_REQ,
	input wire logic [31:0] D0_ADDR,
	output logic D0_GRANT,
	input wire logic D1_REQ,
	input wire logic [31:0] D1_ADDR,
	output logic D1_GRANT,
	input wire logic PERIPH_REQ,
	input wire logic [31:0] PERIPH_ADDR,
	output logic PERIPH_GRANT
);
	typedef enum {ST_IDLE, ST_FILL_INT, ST_WAIT_INT, ST_FILL_EXT} fetch_e;

	logic rst_meta_n;
	logic rst_n;
	logic [2:0] cache_mode;
	logic [31:0] inv_start;
	logic [cache_pkg::INV_COUNT_W-1:0] inv_count;
	logic inv_busy;
	logic [cache_pkg::LADDR_W-1:0] inv_line;
	logic [cache_pkg::LADDR_W-1:0] inv_last;
	logic [31:0] inv_end_addr;
	logic [cache_pkg::LINE_COUNT-1:0] line_valid;
	logic [cache_pkg::TAG_W-1:0] line_tag [cache_pkg::LINE_COUNT];
	logic [cache_pkg::LINE_W-1:0] line_data [cache_pkg::LINE_COUNT];
	fetch_e state;
	logic [31:0] miss_addr;
	logic [cache_pkg::INDEX_W-1:0] fetch_index;
	logic [cache_pkg::TAG_W-1:0] fetch_tag;
	logic [cache_pkg::INDEX_W-1:0] miss_index;
	logic [cache_pkg::INDEX_W-1:0] inv_index;
	logic hits_allowed;
	logic fills_allowed;
	logic fetch_take;
	logic fetch_hit;
	logic fill_done;
	logic [cache_pkg::LINE_W-1:0] fill_line;
	logic fill_req;
	logic [cache_pkg::NUM_REQ-1:0] acc_req;
	logic [cache_pkg::NUM_REQ-1:0] acc_grant;
	logic [31:0] acc_addr [cache_pkg::NUM_REQ];
	logic [1:0] acc_kind [cache_pkg::NUM_REQ];

	// page of an internal address, or none
	function automatic cache_pkg::page_t page_of(input logic [31:0] a);
		cache_pkg::page_t p;
		p = cache_pkg::PAGE_NONE;
		if (a[31:cache_pkg::REGION_LSB] == cache_pkg::REGION_ROM && a[27:cache_pkg::ROM_LIMIT_LSB] == '0) begin
			p = a[cache_pkg::ROM_PAGE_BIT] ? cache_pkg::PAGE_ROM1 : cache_pkg::PAGE_ROM0;
		end else if (a[31:cache_pkg::REGION_LSB] == cache_pkg::REGION_RAM && a[27:cache_pkg::RAM_LIMIT_LSB] == '0) begin
			p = cache_pkg::PAGE_RAM;
		end
		return p;
	endfunction

	// bank slots touched; a slot is one 32-bit RAM bank or half a 64-bit ROM bank
	function automatic logic [cache_pkg::SLOT_COUNT-1:0] slots_of(input logic [31:0] a, input logic [1:0] kind);
		logic [cache_pkg::SLOT_COUNT-1:0] m;
		m = 8'h03 << {a[4:3], 1'b0};
		if (kind == cache_pkg::KIND_LINE) begin
			m = 8'hff; // R20
		end else if (kind == cache_pkg::KIND_NARROW && page_of(a) == cache_pkg::PAGE_RAM) begin
			m = 8'h01 << a[4:2]; // R17
		end
		return m; // R16
	endfunction

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// register writes
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			cache_mode <= cache_pkg::MODE_RESET; // R6
			inv_start <= 32'h0000_0000;
			inv_count <= '0;
		end else if (REG_WR) begin
			if (REG_ADDR == cache_pkg::PROC_CTRL_ADDR) begin
				cache_mode <= REG_WDATA[cache_pkg::MODE_MSB:cache_pkg::MODE_LSB]; // R6
			end
			if (REG_ADDR == cache_pkg::INV_START_ADDR) begin
				inv_start <= REG_WDATA; // R13
			end
			if (REG_ADDR == cache_pkg::INV_CTRL_ADDR) begin
				inv_count <= REG_WDATA[cache_pkg::INV_COUNT_W-1:0]; // R13
			end
		end
	end

	// register reads, data in the following cycle
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			REG_RDATA <= 32'h0000_0000;
		end else if (REG_RD) begin
			case (REG_ADDR)
				cache_pkg::INV_START_ADDR: REG_RDATA <= inv_start;
				cache_pkg::INV_CTRL_ADDR: begin
					REG_RDATA <= 32'h0000_0000;
					REG_RDATA[cache_pkg::INV_COUNT_W-1:0] <= inv_count;
					REG_RDATA[cache_pkg::CTRL_BUSY_BIT] <= inv_busy;
				end
				cache_pkg::PROC_CTRL_ADDR: begin
					REG_RDATA <= 32'h0000_0000;
					REG_RDATA[cache_pkg::MODE_MSB:cache_pkg::MODE_LSB] <= cache_mode;
				end
				default: REG_RDATA <= 32'h0000_0000;
			endcase
		end else begin
			REG_RDATA <= 32'h0000_0000;
		end
	end

	// invalidate walk: one line per cycle from start to last word
	assign inv_end_addr = REG_WDATA[31:0] == 32'h0 ? inv_start : inv_start + {14'h0000, REG_WDATA[15:0], 2'b00} - 32'h1;

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			inv_busy <= 1'b0;
			inv_line <= '0;
			inv_last <= '0;
		end else if (REG_WR && REG_ADDR == cache_pkg::INV_CTRL_ADDR && REG_WDATA[cache_pkg::INV_COUNT_W-1:0] != '0) begin
			inv_busy <= 1'b1; // R13
			inv_line <= inv_start[31:cache_pkg::INDEX_LSB];
			inv_last <= inv_end_addr[31:cache_pkg::INDEX_LSB];
		end else if (inv_busy) begin
			if (inv_line == inv_last) begin
				inv_busy <= 1'b0;
			end else begin
				inv_line <= inv_line + 27'h1;
			end
		end
	end

	assign inv_index = inv_line[cache_pkg::INDEX_W-1:0];

	// mode decode; reserved codes behave as bypass
	always_comb begin
		hits_allowed = 1'b0;
		fills_allowed = 1'b0;
		case (cache_mode)
			cache_pkg::MODE_LEGACY: begin
				hits_allowed = 1'b1; // R10
				fills_allowed = 1'b1; // R10
			end
			cache_pkg::MODE_ENABLE: begin
				hits_allowed = 1'b1; // R7
				fills_allowed = 1'b1; // R7
			end
			cache_pkg::MODE_FREEZE: begin
				hits_allowed = 1'b1; // R8
			end
			cache_pkg::MODE_BYPASS: begin
				hits_allowed = 1'b0; // R9
			end
			default: begin
				hits_allowed = 1'b0;
			end
		endcase
	end

	assign fetch_index = FETCH_ADDR[cache_pkg::INDEX_MSB:cache_pkg::INDEX_LSB];
	assign fetch_tag = FETCH_ADDR[31:cache_pkg::TAG_LSB];
	assign miss_index = miss_addr[cache_pkg::INDEX_MSB:cache_pkg::INDEX_LSB];
	assign fetch_take = FETCH_REQ && state == ST_IDLE;
	assign fetch_hit = hits_allowed && line_valid[fetch_index] && line_tag[fetch_index] == fetch_tag; // R1
	assign fill_done = (state == ST_WAIT_INT) || (state == ST_FILL_EXT && EXT_ACK);
	assign fill_line = state == ST_WAIT_INT ? FILL_MEM_DATA : EXT_DATA; // R4
	assign FETCH_BUSY = state != ST_IDLE;

	// fetch sequencer
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			miss_addr <= 32'h0000_0000;
		end else begin
			case (state)
				ST_IDLE: begin
					if (fetch_take && !fetch_hit) begin
						miss_addr <= FETCH_ADDR;
						if (page_of(FETCH_ADDR) == cache_pkg::PAGE_NONE) begin
							state <= ST_FILL_EXT; // R5
						end else begin
							state <= ST_FILL_INT; // R3
						end
					end
				end
				ST_FILL_INT: begin
					if (acc_grant[cache_pkg::REQ_FILL]) begin
						state <= ST_WAIT_INT; // R3
					end
				end
				ST_WAIT_INT: state <= ST_IDLE;
				ST_FILL_EXT: begin
					if (EXT_ACK) begin
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// fetch answer
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			FETCH_VALID <= 1'b0;
			FETCH_DATA <= 32'h0000_0000;
		end else if (fetch_take && fetch_hit) begin
			FETCH_VALID <= 1'b1; // R2
			FETCH_DATA <= line_data[fetch_index][FETCH_ADDR[cache_pkg::WORD_MSB:cache_pkg::WORD_LSB]*cache_pkg::WORD_W +: cache_pkg::WORD_W];
		end else if (fill_done) begin
			FETCH_VALID <= 1'b1; // R3
			FETCH_DATA <= fill_line[miss_addr[cache_pkg::WORD_MSB:cache_pkg::WORD_LSB]*cache_pkg::WORD_W +: cache_pkg::WORD_W];
		end else begin
			FETCH_VALID <= 1'b0;
		end
	end

	// tags and valid bits; invalidation checks the old tag, so a same-cycle fill of the line wins unless that tag already matched
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			line_valid <= '0;
		end else begin
			if (fill_done && fills_allowed) begin
				line_valid[miss_index] <= 1'b1; // R7
				line_tag[miss_index] <= miss_addr[31:cache_pkg::TAG_LSB];
			end
			if (inv_busy && line_tag[inv_index] == inv_line[cache_pkg::LADDR_W-1:cache_pkg::INDEX_W]) begin
				line_valid[inv_index] <= 1'b0; // R12
			end
		end
	end

	// line storage, whole line written at once
	always_ff @(posedge SYS_CLK) begin
		if (fill_done && fills_allowed) begin
			line_data[miss_index] <= fill_line; // R4
		end
	end

	// external fill request
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			EXT_REQ <= 1'b0;
			EXT_ADDR <= 32'h0000_0000;
		end else if (fetch_take && !fetch_hit && page_of(FETCH_ADDR) == cache_pkg::PAGE_NONE) begin
			EXT_REQ <= 1'b1; // R5
			EXT_ADDR <= {FETCH_ADDR[31:cache_pkg::INDEX_LSB], 5'h00};
		end else if (EXT_ACK) begin
			EXT_REQ <= 1'b0;
		end
	end

	// internal memory requesters
	assign fill_req = state == ST_FILL_INT;
	assign acc_req = {PERIPH_REQ, D1_REQ, D0_REQ, fill_req}; // R19
	assign acc_addr[cache_pkg::REQ_FILL] = {miss_addr[31:cache_pkg::INDEX_LSB], 5'h00};
	assign acc_addr[cache_pkg::REQ_D0] = D0_ADDR;
	assign acc_addr[cache_pkg::REQ_D1] = D1_ADDR;
	assign acc_addr[cache_pkg::REQ_PERIPH] = PERIPH_ADDR;
	assign acc_kind[cache_pkg::REQ_FILL] = cache_pkg::KIND_LINE;
	assign acc_kind[cache_pkg::REQ_D0] = cache_pkg::KIND_WIDE;
	assign acc_kind[cache_pkg::REQ_D1] = cache_pkg::KIND_WIDE;
	assign acc_kind[cache_pkg::REQ_PERIPH] = cache_pkg::KIND_NARROW;

	// fixed-priority bank arbiter: fill, data 0, data 1, peripheral
	always_comb begin
		logic [cache_pkg::SLOT_COUNT-1:0] used [cache_pkg::PAGE_COUNT];
		logic [cache_pkg::SLOT_COUNT-1:0] want;
		logic [1:0] granted;
		for (int p = 0; p < cache_pkg::PAGE_COUNT; p++) begin
			used[p] = '0;
		end
		want = '0;
		granted = 2'h0;
		acc_grant = '0;
		for (int i = 0; i < cache_pkg::NUM_REQ; i++) begin
			if (acc_req[i]) begin
				if (page_of(acc_addr[i]) == cache_pkg::PAGE_NONE) begin
					acc_grant[i] = 1'b1;
				end else begin
					want = slots_of(acc_addr[i], acc_kind[i]);
					if ((used[page_of(acc_addr[i])] & want) == '0 && granted < cache_pkg::MAX_GRANTS) begin
						acc_grant[i] = 1'b1; // R18
						used[page_of(acc_addr[i])] = used[page_of(acc_addr[i])] | want; // R21
						granted = granted + 2'h1;
					end
				end
			end
		end
	end

	// stalled requesters see no grant and retry next cycle
	assign D0_GRANT = acc_grant[cache_pkg::REQ_D0]; // R22
	assign D1_GRANT = acc_grant[cache_pkg::REQ_D1]; // R22
	assign PERIPH_GRANT = acc_grant[cache_pkg::REQ_PERIPH]; // R22
	assign FILL_MEM_EN = acc_grant[cache_pkg::REQ_FILL];
	assign FILL_MEM_ADDR = acc_addr[cache_pkg::REQ_FILL];
endmodule

`default_nettype wire

// >>> src/cache_pkg.sv
// constants for the program cache and internal memory controller
package cache_pkg;
	// register byte addresses
	localparam logic [31:0] INV_START_ADDR = 32'h2000_0000;
	localparam logic [31:0] INV_CTRL_ADDR = 32'h2000_0004;
	localparam logic [31:0] PROC_CTRL_ADDR = 32'h2000_0008;
	// cache mode field of the processor control register
	localparam int MODE_LSB = 5;
	localparam int MODE_MSB = 7;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [2:0] MODE_LEGACY = 3'h0;
	localparam logic [2:0] MODE_ENABLE = 3'h2;
	localparam logic [2:0] MODE_FREEZE = 3'h3;
	localparam logic [2:0] MODE_BYPASS = 3'h4;
	// invalidate control fields
	localparam int INV_COUNT_W = 16;
	localparam int CTRL_BUSY_BIT = 31;
	// cache geometry: 32 KiB, 256-bit lines, direct mapped
	localparam int LINE_COUNT = 1024;
	localparam int LINE_W = 256;
	localparam int WORD_W = 32;
	localparam int INDEX_W = 10;
	localparam int TAG_W = 17;
	localparam int LADDR_W = 27;
	localparam int INDEX_LSB = 5;
	localparam int INDEX_MSB = 14;
	localparam int TAG_LSB = 15;
	localparam int WORD_LSB = 2;
	localparam int WORD_MSB = 4;
	// internal memory decode
	localparam int REGION_LSB = 28;
	localparam logic [3:0] REGION_ROM = 4'h0;
	localparam logic [3:0] REGION_RAM = 4'h1;
	localparam int ROM_PAGE_BIT = 18;
	localparam int ROM_LIMIT_LSB = 19;
	localparam int RAM_LIMIT_LSB = 18;
	typedef logic [1:0] page_t;
	localparam page_t PAGE_ROM0 = 2'h0;
	localparam page_t PAGE_ROM1 = 2'h1;
	localparam page_t PAGE_RAM = 2'h2;
	localparam page_t PAGE_NONE = 2'h3;
	localparam int PAGE_COUNT = 3;
	localparam int SLOT_COUNT = 8;
	// requesters, in grant priority order
	localparam int NUM_REQ = 4;
	localparam logic [1:0] MAX_GRANTS = 2'h3;
	localparam int REQ_FILL = 0;
	localparam int REQ_D0 = 1;
	localparam int REQ_D1 = 2;
	localparam int REQ_PERIPH = 3;
	// access kinds for bank slot masks
	localparam logic [1:0] KIND_WIDE = 2'h0;
	localparam logic [1:0] KIND_NARROW = 2'h1;
	localparam logic [1:0] KIND_LINE = 2'h2;
endpackage

// >>> sim/progcache_checker.sv
// assertion checker for the program cache ports
`timescale 1ns/1ps
`default_nettype none
module progcache_checker (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic [31:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic FETCH_REQ,
	input wire logic [31:0] FETCH_ADDR,
	input wire logic FETCH_BUSY,
	input wire logic FETCH_VALID,
	input wire logic FILL_MEM_EN,
	input wire logic [31:0] FILL_MEM_ADDR,
	input wire logic EXT_REQ,
	input wire logic EXT_ACK,
	input wire logic D0_REQ,
	input wire logic [31:0] D0_ADDR,
	input wire logic D0_GRANT,
	input wire logic D1_REQ,
	input wire logic [31:0] D1_ADDR,
	input wire logic D1_GRANT,
	input wire logic PERIPH_REQ,
	input wire logic [31:0] PERIPH_ADDR,
	input wire logic PERIPH_GRANT
);
	logic [2:0] mode_sh;
	logic take;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	function automatic cache_pkg::page_t pg(input logic [31:0] a);
		if (a[31:28] == cache_pkg::REGION_ROM && a[27:19] == 9'h0) return a[18] ? cache_pkg::PAGE_ROM1 : cache_pkg::PAGE_ROM0;
		if (a[31:28] == cache_pkg::REGION_RAM && a[27:18] == 10'h0) return cache_pkg::PAGE_RAM;
		return cache_pkg::PAGE_NONE;
	endfunction
	// software view of the mode field
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			mode_sh <= cache_pkg::MODE_RESET;
		end else if (REG_WR && REG_ADDR == cache_pkg::PROC_CTRL_ADDR) begin
			mode_sh <= REG_WDATA[7:5];
		end
	end
	assign take = FETCH_REQ && !FETCH_BUSY;
	property p_mode_read;
		REG_RD && REG_ADDR == cache_pkg::PROC_CTRL_ADDR |=> REG_RDATA == {24'h0, mode_sh, 5'h0};
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode field readback wrong");
	property p_take;
		take |=> FETCH_VALID || FETCH_BUSY;
	endproperty
	a_take: assert property (p_take) else $error("fetch neither answered nor missed");
	property p_miss_time;
		take ##1 FILL_MEM_EN |-> ##2 FETCH_VALID;
	endproperty
	a_miss_time: assert property (p_miss_time) else $error("internal miss not two cycles");
	property p_fill_addr;
		take ##1 FILL_MEM_EN |-> FILL_MEM_ADDR == ($past(FETCH_ADDR) & 32'hffff_ffe0);
	endproperty
	a_fill_addr: assert property (p_fill_addr) else $error("fill line address wrong");
	property p_ext_done;
		EXT_ACK |=> FETCH_VALID && !EXT_REQ;
	endproperty
	a_ext_done: assert property (p_ext_done) else $error("external line not delivered");
	property p_fill_page;
		FILL_MEM_EN && D1_REQ && pg(D1_ADDR) == pg(FILL_MEM_ADDR) |-> !D1_GRANT;
	endproperty
	a_fill_page: assert property (p_fill_page) else $error("data grant on fill page");
	property p_d0_free;
		D0_REQ && !(FILL_MEM_EN && pg(D0_ADDR) == pg(FILL_MEM_ADDR)) |-> D0_GRANT;
	endproperty
	a_d0_free: assert property (p_d0_free) else $error("free data access stalled");
	property p_d1_clash;
		D0_REQ && D1_REQ && pg(D0_ADDR) != cache_pkg::PAGE_NONE && pg(D0_ADDR) == pg(D1_ADDR)
			&& D0_ADDR[4:3] == D1_ADDR[4:3] |-> !D1_GRANT;
	endproperty
	a_d1_clash: assert property (p_d1_clash) else $error("bank clash granted twice");
	property p_limit;
		$countones({FILL_MEM_EN, D0_REQ && D0_GRANT && pg(D0_ADDR) != cache_pkg::PAGE_NONE,
			D1_REQ && D1_GRANT && pg(D1_ADDR) != cache_pkg::PAGE_NONE,
			PERIPH_REQ && PERIPH_GRANT && pg(PERIPH_ADDR) != cache_pkg::PAGE_NONE}) <= 3;
	endproperty
	a_limit: assert property (p_limit) else $error("more than three internal accesses");
	c_fill: cover property (take ##1 FILL_MEM_EN);
	c_ext: cover property (EXT_ACK);
	c_periph_stall: cover property (FILL_MEM_EN && PERIPH_REQ && !PERIPH_GRANT);
	c_clash: cover property (D1_REQ && !D1_GRANT && !FILL_MEM_EN);
endmodule
bind progcache progcache_checker progcache_checker_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
	.REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FETCH_REQ(FETCH_REQ),
	.FETCH_ADDR(FETCH_ADDR), .FETCH_BUSY(FETCH_BUSY), .FETCH_VALID(FETCH_VALID), .FILL_MEM_EN(FILL_MEM_EN),
	.FILL_MEM_ADDR(FILL_MEM_ADDR), .EXT_REQ(EXT_REQ), .EXT_ACK(EXT_ACK), .D0_REQ(D0_REQ), .D0_ADDR(D0_ADDR),
	.D0_GRANT(D0_GRANT), .D1_REQ(D1_REQ), .D1_ADDR(D1_ADDR), .D1_GRANT(D1_GRANT), .PERIPH_REQ(PERIPH_REQ),
	.PERIPH_ADDR(PERIPH_ADDR), .PERIPH_GRANT(PERIPH_GRANT));
`default_nettype wire

// >>> sim/memmodel.sv
// far-side model: internal line memory and external memory
`timescale 1ns/1ps
`default_nettype none
module memmodel (
	input wire logic clk,
	input wire logic fill_en,
	input wire logic [31:0] fill_addr,
	output logic [255:0] fill_data,
	input wire logic ext_req,
	input wire logic [31:0] ext_addr,
	output logic ext_ack,
	output logic [255:0] ext_data,
	input wire logic [7:0] gen,
	input wire logic [3:0] ext_wait
);
	logic fill_v;
	logic [31:0] fill_a;
	logic [3:0] cnt;
	// word k of a line is its own byte address, gen marks rewritten memory
	function automatic logic [255:0] line(input logic [31:0] a, input logic [7:0] g);
		for (int k = 0; k < 8; k++) begin
			line[32*k +: 32] = {a[31:5], k[2:0], 2'h0} ^ {g, 24'h0};
		end
	endfunction
	always_ff @(posedge clk) begin
		fill_v <= fill_en;
		fill_a <= fill_addr;
	end
	// line one cycle after the read, inverted junk otherwise
	assign fill_data = fill_v ? line(fill_a, gen) : ~line(fill_a, gen);
	always_ff @(posedge clk) begin
		ext_ack <= ext_req && !ext_ack && cnt == ext_wait;
		cnt <= (ext_req && !ext_ack) ? cnt + 4'h1 : 4'h0;
	end
	assign ext_data = ext_ack ? line(ext_addr, gen) : ~line(ext_addr, gen);
endmodule
`default_nettype wire

// >>> sim/tb.sv
// self-checking testbench for the program cache
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic SYS_CLK, RST_B, REG_WR, REG_RD, FETCH_REQ, FETCH_BUSY, FETCH_VALID, FILL_MEM_EN, EXT_REQ, EXT_ACK;
	logic D0_REQ, D1_REQ, PERIPH_REQ, D0_GRANT, D1_GRANT, PERIPH_GRANT;
	logic [31:0] REG_ADDR, REG_WDATA, REG_RDATA, FETCH_ADDR, FETCH_DATA, FILL_MEM_ADDR, EXT_ADDR;
	logic [31:0] D0_ADDR, D1_ADDR, PERIPH_ADDR, d;
	logic [255:0] FILL_MEM_DATA, EXT_DATA;
	logic [7:0] gen;
	logic [3:0] ext_wait;
	int n_errors = 0;
	int total_checks = 0;
	progcache progcache_i (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FETCH_REQ(FETCH_REQ), .FETCH_ADDR(FETCH_ADDR),
		.FETCH_BUSY(FETCH_BUSY), .FETCH_VALID(FETCH_VALID), .FETCH_DATA(FETCH_DATA), .FILL_MEM_EN(FILL_MEM_EN),
		.FILL_MEM_ADDR(FILL_MEM_ADDR), .FILL_MEM_DATA(FILL_MEM_DATA), .EXT_REQ(EXT_REQ), .EXT_ADDR(EXT_ADDR),
		.EXT_ACK(EXT_ACK), .EXT_DATA(EXT_DATA), .D0_REQ(D0_REQ), .D0_ADDR(D0_ADDR), .D0_GRANT(D0_GRANT),
		.D1_REQ(D1_REQ), .D1_ADDR(D1_ADDR), .D1_GRANT(D1_GRANT), .PERIPH_REQ(PERIPH_REQ),
		.PERIPH_ADDR(PERIPH_ADDR), .PERIPH_GRANT(PERIPH_GRANT));
	memmodel memmodel_i (.clk(SYS_CLK), .fill_en(FILL_MEM_EN), .fill_addr(FILL_MEM_ADDR), .fill_data(FILL_MEM_DATA),
		.ext_req(EXT_REQ), .ext_addr(EXT_ADDR), .ext_ack(EXT_ACK), .ext_data(EXT_DATA), .gen(gen), .ext_wait(ext_wait));
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_WDATA <= v;
		REG_WR <= 1'b1;
		@(posedge SYS_CLK);
		REG_WR <= 1'b0;
	endtask
	task automatic mode(input logic [2:0] m);
		wr(cache_pkg::PROC_CTRL_ADDR, {24'h0, m, 5'h0});
	endtask
	task automatic rdv(input logic [31:0] a, output logic [31:0] v);
		@(posedge SYS_CLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge SYS_CLK);
		REG_RD <= 1'b0;
		#1;
		v = REG_RDATA;
	endtask
	// lat counts edges from the taking edge; lat 0 leaves it unchecked
	task automatic fetch(input logic [31:0] a, input logic [7:0] g, input int lat);
		int n;
		@(posedge SYS_CLK);
		FETCH_ADDR <= a;
		FETCH_REQ <= 1'b1;
		@(posedge SYS_CLK);
		FETCH_REQ <= 1'b0;
		n = 1;
		#1;
		while (FETCH_VALID !== 1'b1) begin
			@(posedge SYS_CLK);
			#1;
			n++;
			if (n > 200) begin
				n_errors++;
				conclude();
			end
		end
		chk(FETCH_DATA, {a[31:2], 2'h0} ^ {g, 24'h0}, "fetch data");
		if (lat > 0) chk(n, lat, "fetch latency");
	endtask
	// requests stay up after the check
	task automatic arb(input logic [31:0] a0, input logic [31:0] a1, input logic [31:0] ap, input logic [2:0] exp);
		@(posedge SYS_CLK);
		D0_ADDR <= a0;
		D1_ADDR <= a1;
		PERIPH_ADDR <= ap;
		{D0_REQ, D1_REQ, PERIPH_REQ} <= 3'h7;
		#1;
		chk(32'({D0_GRANT, D1_GRANT, PERIPH_GRANT}), 32'(exp), "grants");
	endtask
	initial begin
		SYS_CLK = 1'b0;
		forever #25 SYS_CLK = ~SYS_CLK;
	end
	initial begin
		RST_B = 1'b0;
		{REG_WR, REG_RD, FETCH_REQ, D0_REQ, D1_REQ, PERIPH_REQ} = 6'h0;
		{REG_ADDR, REG_WDATA, FETCH_ADDR, D0_ADDR, D1_ADDR, PERIPH_ADDR} = 192'h0;
		gen = 8'h0;
		ext_wait = 4'h0;
		repeat (20) @(posedge SYS_CLK);
		RST_B <= 1'b1;
		repeat (4) @(posedge SYS_CLK);
		rdv(cache_pkg::PROC_CTRL_ADDR, d);
		chk(d, 32'h0, "mode after reset");
		wr(32'h2000_0010, 32'hffff_ffff);
		rdv(32'h2000_0010, d);
		chk(d, 32'h0, "unmapped read");
		wr(cache_pkg::INV_START_ADDR, 32'h1234_5678);
		rdv(cache_pkg::INV_START_ADDR, d);
		chk(d, 32'h1234_5678, "start address readback");
		fetch(32'h0000_0100, 8'h0, 3);
		fetch(32'h0000_0104, 8'h0, 1);
		fetch(32'h0000_011c, 8'h0, 1);
		mode(cache_pkg::MODE_ENABLE);
		rdv(cache_pkg::PROC_CTRL_ADDR, d);
		chk(d, 32'h40, "mode readback");
		fetch(32'h1000_0040, 8'h0, 3);
		fetch(32'h1000_0044, 8'h0, 1);
		fetch(32'h8000_0020, 8'h0, 0);
		ext_wait = 4'h6;
		fetch(32'h8000_0040, 8'h0, 0);
		fetch(32'h8000_0024, 8'h0, 1);
		fetch(32'h8000_005c, 8'h0, 1);
		gen <= 8'h5a;
		mode(cache_pkg::MODE_FREEZE);
		fetch(32'h0000_0104, 8'h0, 1);
		fetch(32'h0000_0200, 8'h5a, 3);
		fetch(32'h0000_0200, 8'h5a, 3);
		mode(cache_pkg::MODE_BYPASS);
		fetch(32'h0000_0104, 8'h5a, 3);
		mode(cache_pkg::MODE_ENABLE);
		fetch(32'h0000_0104, 8'h0, 1);
		wr(cache_pkg::INV_START_ADDR, 32'h0000_0100);
		wr(cache_pkg::INV_CTRL_ADDR, 32'h0000_0008);
		for (int i = 0; i < 50; i++) begin
			rdv(cache_pkg::INV_CTRL_ADDR, d);
			if (d[31] === 1'b0) break;
		end
		chk(d, 32'h0000_0008, "invalidate finished");
		fetch(32'h0000_0104, 8'h5a, 3);
		fetch(32'h8000_0044, 8'h0, 1);
		arb(32'h0, 32'h8, 32'h1000_0010, 3'h7);
		arb(32'h0, 32'h0, 32'h1000_0010, 3'h5);
		arb(32'h0, 32'h4_0000, 32'h1000_0000, 3'h7);
		arb(32'h1000_0000, 32'h1000_0008, 32'h1000_0004, 3'h6);
		arb(32'h1000_0000, 32'h1000_0008, 32'h1000_0010, 3'h7);
		arb(32'h8000_0000, 32'h8000_0000, 32'h8000_0000, 3'h7);
		arb(32'h4_0000, 32'h0, 32'h1000_0000, 3'h7);
		fetch(32'h0000_0300, 8'h5a, 3);
		arb(32'h4_0000, 32'h4_0008, 32'h1000_0000, 3'h7);
		fetch(32'h0000_0400, 8'h5a, 3);
		@(posedge SYS_CLK);
		{D0_REQ, D1_REQ, PERIPH_REQ} <= 3'h0;
		repeat (2) @(posedge SYS_CLK);
		conclude();
	end
endmodule
`default_nettype wire
